// file: inc/icr_pkg.sv
// package: register map, field layout and codes for the input channel ten config block
package icr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] CFG_OFFSET = 8'h29;
    localparam logic [7:0] CFG_RESET  = 8'h03;
    localparam logic [7:0] CFG_MASK   = 8'hFF;
    localparam int DIVN_BIT    = 7;
    localparam int LOCK8K_BIT  = 6;
    localparam int BUCKET_HI   = 5;
    localparam int BUCKET_LO   = 4;
    localparam int FREQ_HI     = 3;
    localparam int FREQ_LO     = 0;

    typedef enum logic [1:0] {
        ICR_PATH_DIRECT = 2'b00,
        ICR_PATH_PREDIV = 2'b01,
        ICR_PATH_FIX8K  = 2'b10
    } icr_path_t;

    typedef enum logic [3:0] {
        ICR_F_8K     = 4'h0,
        ICR_F_T1E1   = 4'h1,
        ICR_F_6M48   = 4'h2,
        ICR_F_19M44  = 4'h3,
        ICR_F_25M92  = 4'h4,
        ICR_F_38M88  = 4'h5,
        ICR_F_51M84  = 4'h6,
        ICR_F_77M76  = 4'h7,
        ICR_F_155M52 = 4'h8,
        ICR_F_2K     = 4'h9,
        ICR_F_4K     = 4'hA
    } icr_freq_code_t;

    // decoded nominal rates, in kHz
    localparam logic [17:0] KHZ_8      = 18'h00008;
    localparam logic [17:0] KHZ_1544   = 18'h00608;
    localparam logic [17:0] KHZ_2048   = 18'h00800;
    localparam logic [17:0] KHZ_6480   = 18'h01950;
    localparam logic [17:0] KHZ_19440  = 18'h04BF0;
    localparam logic [17:0] KHZ_25920  = 18'h06540;
    localparam logic [17:0] KHZ_38880  = 18'h097E0;
    localparam logic [17:0] KHZ_51840  = 18'h0CA80;
    localparam logic [17:0] KHZ_77760  = 18'h12FC0;
    localparam logic [17:0] KHZ_155520 = 18'h25F80;
    localparam logic [17:0] KHZ_2      = 18'h00002;
    localparam logic [17:0] KHZ_4      = 18'h00004;
    localparam logic [17:0] KHZ_NONE   = 18'h00000;
endpackage : icr_pkg

// file: logic/icr_freq_decode.sv
// frequency code decoder: code to nominal rate in kHz
`timescale 1ns/1ns
module icr_freq_decode (
    input  wire logic [3:0]  freqCode,
    input  wire logic        t1E1RateSelect,
    output logic      [17:0] nominalKhz,
    output logic             codeValid
);
    import icr_pkg::*;

    always_comb begin
        codeValid  = 1'b1;
        nominalKhz = KHZ_NONE;
        case (freqCode)
            ICR_F_8K:     nominalKhz = KHZ_8;
            ICR_F_T1E1:   nominalKhz = t1E1RateSelect ? KHZ_1544 : KHZ_2048;
            ICR_F_6M48:   nominalKhz = KHZ_6480;
            ICR_F_19M44:  nominalKhz = KHZ_19440;
            ICR_F_25M92:  nominalKhz = KHZ_25920;
            ICR_F_38M88:  nominalKhz = KHZ_38880;
            ICR_F_51M84:  nominalKhz = KHZ_51840;
            ICR_F_77M76:  nominalKhz = KHZ_77760;
            ICR_F_155M52: nominalKhz = KHZ_155520;
            ICR_F_2K:     nominalKhz = KHZ_2;
            ICR_F_4K:     nominalKhz = KHZ_4;
            default: begin
                // unused codes: no rate, flagged so the monitor can ignore the channel
                nominalKhz = KHZ_NONE;
                codeValid  = 1'b0;
            end
        endcase
    end
endmodule : icr_freq_decode

// file: logic/icr_reset_sync.sv
// reset synchroniser: async assert, two-flop release
`timescale 1ns/1ns
module icr_reset_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    output logic      rstSync_n
);
    logic [1:0] stage_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_r <= 2'b00;
        end else begin
            stage_r <= {stage_r[0], 1'b1};
        end
    end

    assign rstSync_n = stage_r[1];
endmodule : icr_reset_sync

// file: logic/icr_channel_config.sv
// input channel ten configuration register with decoded routing outputs
`timescale 1ns/1ns
//
// Operation
// - bit 7 routes channel via programmable pre-divider
// - bit 6 selects fixed divider to 8 kHz
// - pre-divider bit overrides the 8 kHz bit
// - bits 5:4 pick one of four buckets
// - bits 3:0 hold nominal reference frequency code
module icr_channel_config (
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic [icr_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [icr_pkg::DATA_W-1:0]  regWrData,
    input  wire logic                        regWrStb,
    input  wire logic                        regRdStb,
    input  wire logic                        t1E1RateSelect,
    output logic      [icr_pkg::DATA_W-1:0]  regRdData,
    output logic                             regAddrHit,
    output logic                             useProgDivider,
    output logic                             useFixed8k,
    output logic                             bypassDividers,
    output logic      [1:0]                  bucketSelect,
    output logic      [3:0]                  freqCode,
    output logic      [17:0]                 nominalKhz,
    output logic                             freqCodeValid,
    output logic                             divFreqMismatch
);
    import icr_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] cfg;
        logic [DATA_W-1:0] rdData;
        logic              hit;
        logic              prog;
        logic              fix8k;
        logic              bypass;
        logic [1:0]        bucket;
        logic [3:0]        freq;
        logic [17:0]       khz;
        logic              valid;
        logic              mismatch;
    } icr_state_t;

    icr_state_t st_r;
    icr_state_t st_nxt;
    logic       rstSync_n;
    logic [17:0] decKhz;
    logic        decValid;

    icr_reset_sync u_rst (
        .clk       (clk),
        .arst_n    (arst_n),
        .rstSync_n (rstSync_n)
    );

    // decode from the value about to be stored so the outputs track the register with no lag
    icr_freq_decode u_dec (
        .freqCode       (st_nxt.cfg[FREQ_HI:FREQ_LO]),
        .t1E1RateSelect (t1E1RateSelect),
        .nominalKhz     (decKhz),
        .codeValid      (decValid)
    );

    function automatic logic addrMatch(input logic [ADDR_W-1:0] a);
        return a == CFG_OFFSET;
    endfunction : addrMatch

    function automatic icr_path_t pathOf(input logic [DATA_W-1:0] c);
        if (c[DIVN_BIT]) begin
            return ICR_PATH_PREDIV;
        end else if (c[LOCK8K_BIT]) begin
            return ICR_PATH_FIX8K;
        end else begin
            return ICR_PATH_DIRECT;
        end
    endfunction : pathOf

    always_comb begin
        st_nxt        = st_r;
        st_nxt.hit    = 1'b0;
        st_nxt.rdData = '0;
        if (regWrStb && addrMatch(regAddr)) begin
            st_nxt.cfg = regWrData & CFG_MASK;
        end
        // unmapped reads return zero; reads have no side effect
        if (regRdStb && addrMatch(regAddr)) begin
            st_nxt.rdData = st_r.cfg;
            st_nxt.hit    = 1'b1;
        end else if (regWrStb && addrMatch(regAddr)) begin
            st_nxt.hit = 1'b1;
        end
        // one flop per route flag so no decode sits between register and pin
        st_nxt.prog   = (pathOf(st_nxt.cfg) == ICR_PATH_PREDIV);
        st_nxt.fix8k  = (pathOf(st_nxt.cfg) == ICR_PATH_FIX8K);
        st_nxt.bypass = (pathOf(st_nxt.cfg) == ICR_PATH_DIRECT);
        st_nxt.bucket = st_nxt.cfg[BUCKET_HI:BUCKET_LO];
        st_nxt.freq   = st_nxt.cfg[FREQ_HI:FREQ_LO];
        st_nxt.khz    = decKhz;
        st_nxt.valid  = decValid;
        // advisory only; hardware still honours whatever code is stored
        st_nxt.mismatch = st_nxt.cfg[DIVN_BIT]
                          && (st_nxt.cfg[FREQ_HI:FREQ_LO] != ICR_F_8K);
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            st_r          <= '0;
            st_r.cfg      <= CFG_RESET;
            st_r.bypass   <= 1'b1;
            st_r.freq     <= CFG_RESET[FREQ_HI:FREQ_LO];
            st_r.khz      <= KHZ_19440;
            st_r.valid    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData       = st_r.rdData;
    assign regAddrHit      = st_r.hit;
    assign useProgDivider  = st_r.prog;
    assign useFixed8k      = st_r.fix8k;
    assign bypassDividers  = st_r.bypass;
    assign bucketSelect    = st_r.bucket;
    assign freqCode        = st_r.freq;
    assign nominalKhz      = st_r.khz;
    assign freqCodeValid   = st_r.valid;
    assign divFreqMismatch = st_r.mismatch;
endmodule : icr_channel_config

// file: tb/icr_channel_config_asserts.sv
// checker: port assertions for the channel ten config register
`timescale 1ns/1ns
module icr_channel_config_asserts (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrStb,
    input wire logic        regRdStb,
    input wire logic [7:0]  regRdData,
    input wire logic        regAddrHit,
    input wire logic        useProgDivider,
    input wire logic        useFixed8k,
    input wire logic        bypassDividers,
    input wire logic [1:0]  bucketSelect,
    input wire logic [3:0]  freqCode,
    input wire logic [17:0] nominalKhz,
    input wire logic        freqCodeValid,
    input wire logic        divFreqMismatch,
    input wire logic        t1E1RateSelect
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire wHit = regWrStb && regAddr == 8'h29;
    wire rHit = regRdStb && regAddr == 8'h29;
    AST_PREDIV: assert property (wHit |=> useProgDivider == $past(regWrData[7]))
        else $error("pre-divider route wrong");
    AST_FIX8K: assert property (wHit |=> useFixed8k == ($past(regWrData[6]) && !useProgDivider))
        else $error("fixed divider route wrong");
    AST_ONEPATH: assert property ($onehot({useProgDivider, useFixed8k, bypassDividers}))
        else $error("route not one-hot");
    AST_BUCKET: assert property (wHit |=> bucketSelect == $past(regWrData[5:4]))
        else $error("bucket select wrong");
    AST_FREQ: assert property (wHit |=> freqCode == $past(regWrData[3:0]))
        else $error("freq code wrong");
    AST_RDBACK: assert property (rHit |=> regAddrHit && regRdData[5:0] == {bucketSelect, freqCode})
        else $error("read back wrong");
    AST_MISS: assert property ((regRdStb || regWrStb) && regAddr != 8'h29 |=> !regAddrHit && regRdData == 8'h00)
        else $error("unmapped access answered");
    AST_KHZ: assert property (freqCode == 4'h8 |-> nominalKhz == 18'h25F80 && freqCodeValid)
        else $error("decode of 155 MHz wrong");
    AST_UNUSED: assert property (freqCode > 4'hA |-> !freqCodeValid && nominalKhz == 18'h00000)
        else $error("unused code decoded");
    AST_WHIT: assert property (wHit |=> regAddrHit)
        else $error("write hit missing");
    AST_ADVISE: assert property (divFreqMismatch == (useProgDivider && freqCode != 4'h0))
        else $error("advisory flag wrong");
    AST_T1E1: assert property (freqCode == 4'h1 |-> nominalKhz == ($past(t1E1RateSelect) ? 18'h00608 : 18'h00800))
        else $error("rate select decode wrong");
endmodule : icr_channel_config_asserts
bind icr_channel_config icr_channel_config_asserts u_chk (.clk(clk), .arst_n(arst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .regAddrHit(regAddrHit), .useProgDivider(useProgDivider),
    .useFixed8k(useFixed8k), .bypassDividers(bypassDividers), .bucketSelect(bucketSelect),
    .freqCode(freqCode), .nominalKhz(nominalKhz), .freqCodeValid(freqCodeValid),
    .divFreqMismatch(divFreqMismatch), .t1E1RateSelect(t1E1RateSelect));

// file: tb/tb_input_channel10_ref_config.sv
// testbench: channel ten config register
`timescale 1ns/1ns
module tb_input_channel10_ref_config;
    logic        clk = 0, arst_n = 0, regWrStb = 0, regRdStb = 0, t1E1RateSelect = 0, rdPend = 0;
    logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
    logic        regAddrHit, useProgDivider, useFixed8k, bypassDividers, freqCodeValid, divFreqMismatch;
    logic [1:0]  bucketSelect;
    logic [3:0]  freqCode;
    logic [17:0] nominalKhz;
    logic [8:0]  q[$];
    int          fails = 0, n_checks = 0, cyc = 0;
    logic [17:0] kt [0:10] = '{18'h00008, 18'h00800, 18'h01950, 18'h04BF0, 18'h06540,
        18'h097E0, 18'h0CA80, 18'h12FC0, 18'h25F80, 18'h00002, 18'h00004};
    always #50 clk = ~clk;
    icr_channel_config DUT (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .t1E1RateSelect(t1E1RateSelect), .regRdData(regRdData), .regAddrHit(regAddrHit),
        .useProgDivider(useProgDivider), .useFixed8k(useFixed8k),
        .bypassDividers(bypassDividers), .bucketSelect(bucketSelect), .freqCode(freqCode),
        .nominalKhz(nominalKhz), .freqCodeValid(freqCodeValid),
        .divFreqMismatch(divFreqMismatch));
    task chk(input logic [17:0] g, input logic [17:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task summarize;
        $display("fails=%0d n_checks=%0d", fails, n_checks);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // read: data is the expected read-back, noted for the monitor
    task bus(input logic w, input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        regWrStb <= w;
        regRdStb <= !w;
        regAddr <= a;
        regWrData <= dat;
        t1E1RateSelect <= 1'($urandom);
        if (!w) q.push_back({a == 8'h29, dat});
    endtask : bus
    task idle;
        @(posedge clk);
        regWrStb <= 0;
        regRdStb <= 0;
    endtask : idle
    task outs(input logic [7:0] v);
        @(negedge clk);
        chk({useProgDivider, useFixed8k, bypassDividers}, {v[7], !v[7] && v[6], !v[7] && !v[6]});
        chk({bucketSelect, freqCode}, v[5:0]);
        chk(nominalKhz, v[3:0] == 4'h1 ? (t1E1RateSelect ? 18'h00608 : 18'h00800)
            : v[3:0] > 4'hA ? 18'h00000 : kt[v[3:0]]);
        chk(freqCodeValid, v[3:0] <= 4'hA);
        chk(divFreqMismatch, v[7] && v[3:0] != 4'h0);
    endtask : outs
    // monitor: a read answer stands only in the cycle after the strobe
    always @(posedge clk) rdPend <= regRdStb;
    always @(negedge clk) if (rdPend) chk({regAddrHit, regRdData}, q.pop_front());
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        void'($urandom(48));
        repeat (6) @(posedge clk);
        arst_n <= 1;
        repeat (3) @(posedge clk);
        bus(0, 8'h29, 8'h03);
        idle();
        outs(8'h03);
        for (int i = 0; i < 48; i++) begin
            d = {4'($urandom), i[3:0]};
            bus(1, 8'h29, d);
            bus(0, 8'h29, d);
            idle();
            outs(d);
        end
        // mid-run reset must bring back the default value
        arst_n <= 0;
        repeat (2) @(posedge clk);
        arst_n <= 1;
        repeat (3) @(posedge clk);
        outs(8'h03);
        bus(1, 8'h2A, 8'hFF);
        bus(0, 8'h2A, 8'h00);
        bus(0, 8'h29, 8'h03);
        idle();
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule : tb_input_channel10_ref_config
